// ### hw/sidp_link.sv
// serial-link side of the identification-page block, clocked by the host's serial clock
// assumes mode 0: input sampled on rising edge, output shifted on falling edge;
// frame information is read by the system side only after select has gone high
`timescale 1ns/1ns
`include "sidp_map.svh"

module sidp_link (
    input wire logic sclk_in, // serial clock from host
    input wire logic sel_n_in, // select, active low
    input wire logic mosi_in, // serial data in
    input wire logic rstn_in, // system reset, active low
    input wire logic busy_in, // write cycle running (system clock)
    input wire logic locked_in, // page locked (system clock)
    input wire logic armed_in, // select has fallen since reset (system clock)
    output logic miso_out, // serial data out
    output logic miso_oe_out, // serial data out enable
    output logic tgl_out, // toggles at each clocked frame
    output sidp_pkg::sidp_cmd_t cmd_out, // decoded instruction
    output logic region_out, // id region select bit
    output logic [1:0] data_bytes_out, // data bytes 0, 1, 2 meaning two or more
    output logic aligned_out, // last bit closed a byte
    output logic lock_bit_out, // bit 1 of the first data byte
    output logic [`SIDP_PAGE_BYTES-1:0] mask_out, // bytes staged for writing
    output logic st_we_out, // staging write strobe
    output logic [`SIDP_PTR_W-1:0] st_addr_out, // staging write address
    output logic [7:0] st_data_out, // staging write data
    output logic id_re_out, // id page read strobe
    output logic [`SIDP_PTR_W-1:0] id_raddr_out, // id page read address
    input wire logic [7:0] id_rdata_in // id page read data
);

    logic [2:0] s1;
    logic [2:0] s2;
    logic first;
    logic [2:0] bit_idx;
    logic [1:0] byte_no;
    logic [7:0] sh;
    logic rd_ok;
    logic [`SIDP_PTR_W-1:0] ptr;
    logic load;
    logic [7:0] out_sh;

    // -----------------------------------------------------------------
    // crossings from the system clock
    // -----------------------------------------------------------------
    always_ff @(posedge sclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s1 <= 3'h0;
            s2 <= 3'h0;
        end
        else
        begin
            s1 <= {armed_in, locked_in, busy_in};
            s2 <= s1;
        end
    end

    // marks the first edge of a frame; set while deselected
    always_ff @(posedge sclk_in or posedge sel_n_in)
    begin
        if (sel_n_in)
            first <= 1'b1;
        else
            first <= 1'b0;
    end

    // -----------------------------------------------------------------
    // decoding
    // -----------------------------------------------------------------
    wire [7:0] sh_next = {sh[6:0], mosi_in};
    wire [2:0] cur_idx = first ? 3'h0 : bit_idx;
    wire [1:0] cur_byte = first ? 2'h0 : byte_no;
    wire byte_done = (cur_idx == 3'h7);
    wire addr_done = byte_done && (cur_byte == 2'h2);
    wire data_done = byte_done && (cur_byte == 2'h3);
    wire rd_mode = (cmd_out == sidp_pkg::cmd_read_id) && rd_ok;
    wire wr_page = (cmd_out == sidp_pkg::cmd_write_id) && !region_out;
    wire [`SIDP_PTR_W-1:0] addr_low = sh_next[`SIDP_PTR_W-1:0];
    wire [7:0] src_byte = region_out ? {7'h0, s2[1]} : id_rdata_in;

    assign st_we_out = data_done && wr_page;
    assign st_addr_out = ptr;
    assign st_data_out = sh_next;
    assign id_re_out = rd_mode && !region_out && byte_done && cur_byte[1];
    assign id_raddr_out = addr_done ? addr_low : ptr;
    assign aligned_out = (bit_idx == 3'h0);
    assign miso_out = out_sh[7];
    assign miso_oe_out = !sel_n_in && !first && rd_mode && (byte_no == 2'h3) && s2[2];

    // -----------------------------------------------------------------
    // rising edge: shift in
    // -----------------------------------------------------------------
    always_ff @(posedge sclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            bit_idx <= 3'h0;
            byte_no <= 2'h0;
            sh <= 8'h00;
            tgl_out <= 1'b0;
            cmd_out <= sidp_pkg::cmd_none;
            rd_ok <= 1'b0;
            region_out <= 1'b0;
            data_bytes_out <= 2'h0;
            lock_bit_out <= 1'b0;
            mask_out <= '0;
            ptr <= '0;
            load <= 1'b0;
        end
        else
        begin
            bit_idx <= cur_idx + 3'h1;
            byte_no <= (byte_done && cur_byte != 2'h3) ? cur_byte + 2'h1 : cur_byte;
            sh <= sh_next;
            load <= rd_mode && byte_done && cur_byte[1];
            if (first)
            begin
                tgl_out <= !tgl_out;
                cmd_out <= sidp_pkg::cmd_none;
                region_out <= 1'b0;
                data_bytes_out <= 2'h0;
            end
            if (byte_done && cur_byte == 2'h0)
            begin
                cmd_out <= sidp_pkg::sidp_decode(sh_next);
                rd_ok <= !s2[0];
                mask_out <= '0;
            end
            if (byte_done && cur_byte == 2'h1)
                region_out <= sh_next[`SIDP_REGION_BIT-8];
            if (addr_done)
                ptr <= addr_low + ((cmd_out == sidp_pkg::cmd_read_id) ? 5'h01 : 5'h00);
            if (data_done)
            begin
                if (data_bytes_out == 2'h0)
                    lock_bit_out <= sh_next[`SIDP_LOCK_DATA_BIT];
                if (data_bytes_out != 2'h2)
                    data_bytes_out <= data_bytes_out + 2'h1;
                if (wr_page)
                    mask_out[ptr] <= 1'b1;
            end
            if (data_done && (wr_page || rd_mode))
                ptr <= ptr + 5'h01;
        end
    end

    // -----------------------------------------------------------------
    // falling edge: shift out, lock status repeats each byte
    // -----------------------------------------------------------------
    always_ff @(negedge sclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            out_sh <= 8'h00;
        else if (load)
            out_sh <= src_byte;
        else
            out_sh <= {out_sh[6:0], 1'b0};
    end

endmodule // sidp_link

// ### hw/sidp_map.svh
// constants of the identification-page access block: opcodes, field positions, timing
// assumes nothing; included by the package and the design modules
`ifndef SIDP_MAP_SVH
`define SIDP_MAP_SVH

// -----------------------------------------------------------------
// instruction codes (defaults, adjustable to the target part)
// -----------------------------------------------------------------
`define SIDP_OP_WRITE_ENABLE 8'h06
`define SIDP_OP_READ_ID 8'h83
`define SIDP_OP_WRITE_ID 8'h82

// -----------------------------------------------------------------
// page and address layout
// -----------------------------------------------------------------
`define SIDP_PAGE_BYTES 32
`define SIDP_PTR_W 5
`define SIDP_REGION_BIT 10
`define SIDP_LOCK_DATA_BIT 1
`define SIDP_ERASED_BYTE 8'hFF
`define SIDP_BP_ALL 2'h3

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define SIDP_MCLK_PERIOD_NS 4
`define SIDP_WRITE_CYCLE_TIME_NS 5000000
`define SIDP_WRITE_CYCLES (`SIDP_WRITE_CYCLE_TIME_NS / `SIDP_MCLK_PERIOD_NS)

`endif

// ### hw/sidp_mem.sv
// small two-clock byte memory with registered read data
// assumes writes and reads of one location never overlap in time
`timescale 1ns/1ns
`include "sidp_map.svh"

module sidp_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW = 5,
    parameter logic [7:0] INIT = `SIDP_ERASED_BYTE
) (
    input wire logic wclk_in, // write clock
    input wire logic we_in, // write strobe
    input wire logic [AW-1:0] waddr_in, // write address
    input wire logic [WIDTH-1:0] wdata_in, // write data
    input wire logic rclk_in, // read clock
    input wire logic re_in, // read strobe
    input wire logic [AW-1:0] raddr_in, // read address
    output logic [WIDTH-1:0] rdata_out // registered read data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // contents as delivered: every byte erased
    initial
    begin
        for (int i = 0; i < DEPTH; i++)
            mem[i] = WIDTH'(INIT);
    end

    always_ff @(posedge wclk_in)
    begin
        if (we_in)
            mem[waddr_in] <= wdata_in;
    end

    always_ff @(posedge rclk_in)
    begin
        if (re_in)
            rdata_out <= mem[raddr_in];
    end

endmodule // sidp_mem

// ### hw/sidp_pkg.sv
// types and opcode decoding for the identification-page access block
// assumes sidp_map.svh is on the include path
`include "sidp_map.svh"

package sidp_pkg;

    typedef enum logic [1:0] {
        cmd_none = 2'b00,
        cmd_write_enable_command = 2'b01,
        cmd_read_id = 2'b10,
        cmd_write_id = 2'b11
    } sidp_cmd_t;

    typedef enum logic [1:0] {
        cyc_idle = 2'b00,
        cyc_id_write = 2'b01,
        cyc_lock = 2'b10
    } sidp_cyc_t;

    function automatic sidp_cmd_t sidp_decode(input logic [7:0] op);
        sidp_cmd_t c;
        c = cmd_none;
        if (op == `SIDP_OP_WRITE_ENABLE)
            c = cmd_write_enable_command;
        else if (op == `SIDP_OP_READ_ID)
            c = cmd_read_id;
        else if (op == `SIDP_OP_WRITE_ID)
            c = cmd_write_id;
        return c;
    endfunction

endpackage

// ### hw/sidp_top.sv
// identification-page access block of a serial eeprom: id page read and write,
// lock status read, permanent lock, power-up state of the status bits
// assumes nonvolatile cells are held outside and presented on the nv_*_in ports,
// the serial clock is a separate domain, and the host stops it outside frames
//
// What this block does
// - keeps a separate 32-byte identification page that can be locked read-only
// - id read: instruction, address with region bit 0, byte from low five bits
// - while selected, a read advances the address and sends the next byte
// - select going high ends a read at any bit position
// - an id read issued during a write cycle is ignored
// - id write: instruction, address with region bit 0, data at low five bits
// - lock status read: region bit 1, lowest bit of reply shows the lock
// - the lock status byte repeats while select stays low
// - lock is accepted only with the write enable latch set
// - lock: instruction, address with region bit 1, one data byte with bit 1 set
// - select must rise right after the eighth data bit, else no lock
// - a valid lock starts the self-timed write cycle at select rising
// - lock discarded when busy, both protect bits set, or not byte aligned
// - after power-up, idle; a select falling edge precedes any instruction
// - power-up clears write enable latch and write-in-progress flag
// - protect and status write disable bits persist across power cycles
// - delivered: page bytes read FFh, protect and disable bits zero
// - write-in-progress clears when the write cycle time has elapsed
// - only the write enable command sets the latch; writes need it
`timescale 1ns/1ns
`include "sidp_map.svh"

module sidp_top #(
    parameter int WRITE_CYCLES = `SIDP_WRITE_CYCLES
) (
    input wire logic mclk_in, // system clock
    input wire logic rstn_in, // reset, active low; synchronous to mclk_in, asynchronous in the serial link
    input wire logic sclk_in, // serial clock from host
    input wire logic sel_n_in, // select, active low
    input wire logic mosi_in, // serial data in
    output logic miso_out, // serial data out
    output logic miso_oe_out, // serial data out enable
    input wire logic nv_lock_in, // stored lock cell
    input wire logic nv_bp_high_in, // stored block protect high cell
    input wire logic nv_bp_low_in, // stored block protect low cell
    input wire logic nv_status_write_disable_bit_in, // stored status write disable cell
    output logic write_enable_latch_out, // write enable latch
    output logic write_in_progress_flag_out, // write cycle running
    output logic id_locked_out, // page locked, to be stored
    output logic block_protect_high_out, // block protect high
    output logic block_protect_low_out, // block protect low
    output logic status_write_disable_bit_out // status write disable
);

    localparam int TW = $clog2(WRITE_CYCLES + 1);

    logic sel_s1;
    logic sel_s2;
    logic sel_s3;
    logic tgl_s1;
    logic tgl_s2;
    logic seen_tgl;
    logic armed;
    sidp_pkg::sidp_cyc_t cyc;
    logic [TW-1:0] tmr;
    logic [5:0] copy_idx;
    logic rd_pend;
    logic [`SIDP_PTR_W-1:0] rd_addr;
    logic [`SIDP_PAGE_BYTES-1:0] mask_q;

    logic lk_tgl;
    sidp_pkg::sidp_cmd_t lk_cmd;
    logic lk_region;
    logic [1:0] lk_bytes;
    logic lk_aligned;
    logic lk_lock_bit;
    logic [`SIDP_PAGE_BYTES-1:0] lk_mask;
    logic st_we;
    logic [`SIDP_PTR_W-1:0] st_addr;
    logic [7:0] st_data;
    logic [7:0] st_rdata;
    logic id_re;
    logic [`SIDP_PTR_W-1:0] id_raddr;
    logic [7:0] id_rdata;

    // -----------------------------------------------------------------
    // serial link and the two memories
    // -----------------------------------------------------------------
    sidp_link u_link (
        .sclk_in(sclk_in),
        .sel_n_in(sel_n_in),
        .mosi_in(mosi_in),
        .rstn_in(rstn_in),
        .busy_in(write_in_progress_flag_out),
        .locked_in(id_locked_out),
        .armed_in(armed),
        .miso_out(miso_out),
        .miso_oe_out(miso_oe_out),
        .tgl_out(lk_tgl),
        .cmd_out(lk_cmd),
        .region_out(lk_region),
        .data_bytes_out(lk_bytes),
        .aligned_out(lk_aligned),
        .lock_bit_out(lk_lock_bit),
        .mask_out(lk_mask),
        .st_we_out(st_we),
        .st_addr_out(st_addr),
        .st_data_out(st_data),
        .id_re_out(id_re),
        .id_raddr_out(id_raddr),
        .id_rdata_in(id_rdata)
    );

    // bytes of a write frame wait here until the write cycle copies them
    sidp_mem u_stage (
        .wclk_in(sclk_in),
        .we_in(st_we),
        .waddr_in(st_addr),
        .wdata_in(st_data),
        .rclk_in(mclk_in),
        .re_in(!copy_idx[5]),
        .raddr_in(copy_idx[4:0]),
        .rdata_out(st_rdata)
    );

    // the page itself, delivered erased
    sidp_mem u_page (
        .wclk_in(mclk_in),
        .we_in(rd_pend && mask_q[rd_addr]),
        .waddr_in(rd_addr),
        .wdata_in(st_rdata),
        .rclk_in(sclk_in),
        .re_in(id_re),
        .raddr_in(id_raddr),
        .rdata_out(id_rdata)
    );

    // -----------------------------------------------------------------
    // frame end detection
    // -----------------------------------------------------------------
    wire frame_end = sel_s2 && !sel_s3;
    wire sel_fell = !sel_s2 && sel_s3;
    wire exec = frame_end && (tgl_s2 != seen_tgl) && armed;
    wire busy = write_in_progress_flag_out;
    wire bp_all = ({block_protect_high_out, block_protect_low_out} == `SIDP_BP_ALL);
    wire is_write = (lk_cmd == sidp_pkg::cmd_write_id);
    wire do_write_enable_command = exec && (lk_cmd == sidp_pkg::cmd_write_enable_command) && lk_aligned;
    wire do_page = exec && is_write && !lk_region && (lk_bytes != 2'h0) && lk_aligned
        && write_enable_latch_out && !busy && !id_locked_out;
    wire do_lock = exec && is_write && lk_region && (lk_bytes == 2'h1) && lk_aligned
        && lk_lock_bit && write_enable_latch_out && !busy && !bp_all;
    wire cyc_end = busy && (tmr == '0);

    always_ff @(posedge mclk_in)
    begin
        sel_s1 <= sel_n_in;
        sel_s2 <= sel_s1;
        sel_s3 <= sel_s2;
        tgl_s1 <= lk_tgl;
        tgl_s2 <= tgl_s1;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            seen_tgl <= tgl_s2;
            armed <= 1'b0;
        end
        else
        begin
            if (frame_end)
                seen_tgl <= tgl_s2;
            if (sel_fell)
                armed <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // status bits and the self-timed write cycle
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            write_enable_latch_out <= 1'b0;
            write_in_progress_flag_out <= 1'b0;
            id_locked_out <= nv_lock_in;
            block_protect_high_out <= nv_bp_high_in;
            block_protect_low_out <= nv_bp_low_in;
            status_write_disable_bit_out <= nv_status_write_disable_bit_in;
            cyc <= sidp_pkg::cyc_idle;
            tmr <= '0;
            mask_q <= '0;
        end
        else if (do_page || do_lock)
        begin
            cyc <= do_lock ? sidp_pkg::cyc_lock : sidp_pkg::cyc_id_write;
            write_in_progress_flag_out <= 1'b1;
            tmr <= TW'(WRITE_CYCLES - 1);
            mask_q <= do_page ? lk_mask : '0;
        end
        else if (cyc_end)
        begin
            write_in_progress_flag_out <= 1'b0;
            write_enable_latch_out <= 1'b0;
            if (cyc == sidp_pkg::cyc_lock)
                id_locked_out <= 1'b1;
            cyc <= sidp_pkg::cyc_idle;
        end
        else
        begin
            if (busy)
                tmr <= tmr - TW'(1);
            if (do_write_enable_command)
                write_enable_latch_out <= 1'b1;
        end
    end

    // copy staged bytes into the page during the first cycles of the write
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            copy_idx <= 6'h20;
            rd_pend <= 1'b0;
            rd_addr <= '0;
        end
        else
        begin
            if (do_page)
                copy_idx <= 6'h00;
            else if (!copy_idx[5])
                copy_idx <= copy_idx + 6'h01;
            rd_pend <= !copy_idx[5];
            rd_addr <= copy_idx[4:0];
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);

    power_up_a: assert property (disable iff (1'b0)
        !rstn_in |=> !write_enable_latch_out && !write_in_progress_flag_out)
        else $error("latch or busy flag not cleared by reset");

    wip_end_a: assert property (
        busy && tmr == '0 |=> !write_in_progress_flag_out && !write_enable_latch_out)
        else $error("write cycle did not end when timer expired");

    wip_hold_a: assert property (
        $rose(write_in_progress_flag_out) |-> write_in_progress_flag_out[*8])
        else $error("write cycle shorter than expected");

    lock_gate_a: assert property (
        $rose(write_in_progress_flag_out) && cyc == sidp_pkg::cyc_lock
        |-> $past(write_enable_latch_out) && !$past(bp_all) && $past(lk_aligned))
        else $error("lock started without enable, with full protection or misaligned");

    lock_sticky_a: assert property (
        id_locked_out |=> id_locked_out)
        else $error("lock bit cleared");

    locked_refuse_a: assert property (
        id_locked_out && $rose(write_in_progress_flag_out) |-> cyc != sidp_pkg::cyc_id_write)
        else $error("write to locked page accepted");

    nv_stable_a: assert property (
        $stable(block_protect_high_out) && $stable(block_protect_low_out)
        && $stable(status_write_disable_bit_out))
        else $error("protect or disable bit changed outside reset");

    wel_source_a: assert property (
        $rose(write_enable_latch_out) |-> $past(lk_cmd) == sidp_pkg::cmd_write_enable_command && $past(exec))
        else $error("write enable latch set by other than its command");

    armed_first_a: assert property (
        !armed |-> !$rose(write_in_progress_flag_out) ##1 !write_enable_latch_out)
        else $error("instruction taken before first select fall");

    wip_start_a: assert property (
        do_page |=> write_in_progress_flag_out && cyc == sidp_pkg::cyc_id_write)
        else $error("accepted page write did not start a write cycle");

    lock_end_a: assert property (
        cyc_end && cyc == sidp_pkg::cyc_lock |=> id_locked_out)
        else $error("lock cycle ended without locking the page");

    locked_copy_a: assert property (
        id_locked_out |-> copy_idx[5] && !rd_pend)
        else $error("page copy running while the page is locked");

endmodule // sidp_top

// ### verif/sidp_host.sv
// serial host model: frames with a gated serial clock and read byte capture
// assumes the device shifts miso on the falling clock edge
`timescale 1ns/1ns

module sidp_host (
    output logic sclk_out, // serial clock, still outside frames
    output logic sel_n_out, // select, active low
    output logic mosi_out, // serial data to device
    input wire logic miso_in, // serial data from device
    input wire logic miso_oe_in, // device drives miso
    output logic [7:0] rx_byte_out, // captured read byte
    output logic rx_stb_out, // rises per captured byte
    output logic oe_seen_out // enable seen in last frame
);
    initial
    begin
        sclk_out = 1'b0;
        sel_n_out = 1'b1;
        mosi_out = 1'b0;
        rx_byte_out = 8'h00;
        rx_stb_out = 1'b0;
        oe_seen_out = 1'b0;
    end

    // ------------------------------------------------------------
    // one frame: select low, nbits on the 6 ns clock, select high
    // ------------------------------------------------------------
    task automatic xfer(input logic [7:0] tx [8], input int nbits, input bit rd);
        logic [7:0] sh;
        sh = 8'h00;
        sel_n_out <= 1'b0;
        oe_seen_out = 1'b0;
        #5;
        for (int i = 0; i < nbits; i++)
        begin
            mosi_out = tx[i/8][7-i%8];
            #3 sclk_out = 1'b1;
            sh = {sh[6:0], miso_in};
            oe_seen_out = oe_seen_out | miso_oe_in;
            #3 sclk_out = 1'b0;
            rx_stb_out = 1'b0;
            if (rd && i >= 24 && i % 8 == 7)
            begin
                rx_byte_out = sh;
                rx_stb_out = 1'b1;
            end
        end
        // select rises before any further rising clock edge
        #2 sel_n_out = 1'b1;
        mosi_out = ~mosi_out;
    endtask
endmodule // sidp_host

// ### verif/test_sidp_top.sv
// self-checking bench of the id page block; read bytes are scored from a queue
// assumes sidp_map.svh, the design files and sidp_host.sv are compiled first
`timescale 1ns/1ns
`include "sidp_map.svh"

module test_sidp_top;
    localparam int WC = 100;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic bp = 1'b0;
    logic status_write_disable_bit = 1'b0;
    logic nv_lock = 1'b0;
    wire sclk, sel_n, mosi, miso, miso_oe, stb, oe_seen, write_enable_latch, write_in_progress_flag, lck, bph, bpl, status_write_disable_bit_o;
    wire [7:0] rx;
    logic [7:0] pg [32];
    logic [7:0] exp_q [$];
    logic [7:0] d;
    logic [4:0] a;
    int err_total = 0;
    int check_count = 0;

    always #2 mclk_in = ~mclk_in;
    always @(posedge mclk_in) if (rstn_in) nv_lock <= lck;

    sidp_top #(.WRITE_CYCLES(WC)) u_sidp_top (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .sclk_in(sclk), .sel_n_in(sel_n), .mosi_in(mosi), .miso_out(miso),
        .miso_oe_out(miso_oe), .nv_lock_in(nv_lock), .nv_bp_high_in(bp), .nv_bp_low_in(bp),
        .nv_status_write_disable_bit_in(status_write_disable_bit), .write_enable_latch_out(write_enable_latch), .write_in_progress_flag_out(write_in_progress_flag),
        .id_locked_out(lck), .block_protect_high_out(bph), .block_protect_low_out(bpl),
        .status_write_disable_bit_out(status_write_disable_bit_o));
    sidp_host u_sidp_host (.sclk_out(sclk), .sel_n_out(sel_n), .mosi_out(mosi),
        .miso_in(miso), .miso_oe_in(miso_oe), .rx_byte_out(rx), .rx_stb_out(stb),
        .oe_seen_out(oe_seen));

    // ------------------------------------------------------------
    // compare tasks, scoring of read bytes, frame helpers
    // ------------------------------------------------------------
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask
    always @(posedge stb) chk8("read byte", exp_q.pop_front(), rx);
    task automatic frame(input logic [7:0] b0, b1, b2, b3, b4, input int n, input bit rd);
        logic [7:0] tx [8];
        tx = '{b0, b1, b2, b3, b4, 8'hff, 8'hff, 8'hff};
        u_sidp_host.xfer(tx, n, rd);
        repeat (44) @(posedge mclk_in);
    endtask
    task automatic read_id(input logic [4:0] ad);
        exp_q.push_back(pg[ad]);
        exp_q.push_back(pg[ad+5'h01]);
        frame(`SIDP_OP_READ_ID, 8'($urandom) & 8'hfb, {3'($urandom), ad}, 8'hff, 8'hff, 40,
            1'b1);
        chk1("read oe", 1'b1, oe_seen);
    endtask
    task automatic lock_stat(input logic l);
        exp_q.push_back({7'h00, l});
        exp_q.push_back({7'h00, l});
        frame(`SIDP_OP_READ_ID, 8'($urandom) | 8'h04, 8'($urandom), 8'hff, 8'hff, 40,
            1'b1);
        chk1("status oe", 1'b1, oe_seen);
    endtask
    task automatic write_enable_command();
        frame(`SIDP_OP_WRITE_ENABLE, 8'h00, 8'h00, 8'h00, 8'h00, 8, 1'b0);
        chk1("wel", 1'b1, write_enable_latch);
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while (write_in_progress_flag !== 1'b0 && k < 300)
        begin
            @(posedge mclk_in);
            k++;
        end
        chk1("wip end", 1'b0, write_in_progress_flag);
        chk1("wel end", 1'b0, write_enable_latch);
    endtask
    task automatic do_reset(input logic b);
        @(posedge mclk_in);
        rstn_in <= 1'b0;
        bp <= b;
        status_write_disable_bit <= 1'($urandom);
        repeat (12) @(posedge mclk_in);
        rstn_in <= 1'b1;
        repeat (8) @(posedge mclk_in);
        chk1("wel", 1'b0, write_enable_latch);
        chk1("wip", 1'b0, write_in_progress_flag);
        chk1("bp high", b, bph);
        chk1("bp low", b, bpl);
        chk1("status_write_disable_bit", status_write_disable_bit, status_write_disable_bit_o);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0 && exp_q.size() == 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #60000;
        err_total++;
        end_sim();
    end

    initial
    begin
        void'($urandom(32'hdb8d12bd));
        for (int i = 0; i < 32; i++) pg[i] = `SIDP_ERASED_BYTE;
        do_reset(1'b1);
        read_id(5'($urandom % 30));
        lock_stat(1'b0);
        write_enable_command();
        frame(`SIDP_OP_WRITE_ID, 8'h04, 8'h00, 8'h02, 8'h00, 32, 1'b0);
        chk1("lock with bp 11", 1'b0, write_in_progress_flag);
        do_reset(1'b0);
        a = 5'($urandom % 30);
        frame(`SIDP_OP_WRITE_ID, 8'h00, {3'h0, a}, 8'h5a, 8'h00, 32, 1'b0);
        chk1("write no wel", 1'b0, write_in_progress_flag);
        write_enable_command();
        pg[a] = 8'($urandom);
        pg[a+5'h01] = 8'($urandom);
        frame(`SIDP_OP_WRITE_ID, 8'($urandom) & 8'hfb, {3'($urandom), a}, pg[a],
            pg[a+5'h01], 40, 1'b0);
        chk1("write busy", 1'b1, write_in_progress_flag);
        frame(`SIDP_OP_READ_ID, 8'h00, 8'h00, 8'hff, 8'hff, 40, 1'b0);
        chk1("read while busy", 1'b0, oe_seen);
        wait_idle();
        read_id(a);
        for (int i = 0; i < 4; i++)
        begin
            if (i != 0)
                write_enable_command();
            d = 8'($urandom);
            frame(`SIDP_OP_WRITE_ID, 8'($urandom) | 8'h04, 8'($urandom),
                (i == 1) ? d & 8'hfd : d | 8'h02, 8'h00, (i == 2) ? 33 : 32, 1'b0);
            chk1("lock cycle", i == 3, write_in_progress_flag);
        end
        wait_idle();
        chk1("locked", 1'b1, lck);
        lock_stat(1'b1);
        write_enable_command();
        frame(`SIDP_OP_WRITE_ID, 8'h00, {3'h0, a}, ~pg[a], 8'h00, 32, 1'b0);
        chk1("write locked", 1'b0, write_in_progress_flag);
        read_id(a);
        repeat (20) @(posedge mclk_in);
        end_sim();
    end
endmodule // test_sidp_top
